/* File: design/pflash_pkg.sv */
// Shared constants and carriers for the program flash table access block.
// Assumes a 24-bit program word store behind a simple command/done macro port.
package pflash_pkg;

    // ========================================================================
    // Geometry of the program store
    // ========================================================================
    localparam int ADDR_W     = 24;
    localparam int LOW_W      = 16;
    localparam int PAGE_W     = 8;
    localparam int HIGH_LSB   = 16;
    localparam int ROW_INSTR  = 64;
    localparam int ROW_BYTES  = 192;
    localparam int PAGE_INSTR = 512;
    localparam int PAGE_BYTES = 1536;
    localparam int IDX_W      = 6;
    localparam int ROW_LSB    = 7;
    localparam int ERASE_LSB  = 10;
    localparam logic [5:0]  LAST_IDX    = 6'h3f;
    localparam logic [23:0] ERASED_WORD = 24'hffffff;
    localparam logic [7:0]  PAGE_RESET  = 8'h00;

    // ========================================================================
    // Serial programming frame: command byte, 24-bit address, 16-bit data
    // ========================================================================
    localparam logic [5:0] FRAME_LAST   = 6'h2f;
    localparam logic [4:0] SOUT_BITS    = 5'h10;
    localparam int         CMD_HIGH_BIT = 3;
    localparam int         CMD_BYTE_BIT = 4;

    typedef enum logic [2:0] {
        TBL_READ, TBL_WRITE, TBL_ROW_PROG, TBL_WORD_PROG, TBL_PAGE_ERASE
    } tbl_op_t;

    typedef enum logic [1:0] {FL_READ, FL_WRITE, FL_ERASE} fl_kind_t;

    typedef struct packed {
        logic          valid;
        tbl_op_t       op;
        logic          high;
        logic          byte_mode;
        logic [15:0]   effective_addr;
        logic [15:0]   wdata;
    } tbl_req_t;

    typedef struct packed {
        logic          valid;
        logic [15:0]   rdata;
    } tbl_resp_t;

    typedef struct packed {
        logic          valid;
        fl_kind_t      kind;
        logic [23:0]   addr;
        logic [23:0]   wdata;
    } fl_cmd_t;

endpackage

/* File: design/program_flash_table_access.sv */
// Table read/write access path into the 24-bit program flash, with row latches.
// Assumes a flash macro on sys_clk that answers each command with one done pulse.
`timescale 1ns/1ps
`default_nettype none

module program_flash_table_access (
    // Clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   nrst,
    // Core table instruction port
    input  wire pflash_pkg::tbl_req_t   core_req,
    output var  logic                   core_ready,
    output var  pflash_pkg::tbl_resp_t  core_resp,
    // Page register load
    input  wire logic                   page_wr,
    input  wire logic [7:0]             page_wdata,
    output var  logic [7:0]             table_page_register,
    // Flash macro port
    output var  pflash_pkg::fl_cmd_t    fl_cmd,
    input  wire logic [23:0]            flash_rdata,
    input  wire logic                   flash_done,
    // Serial programming pins
    input  wire logic                   prog_clock_pin,
    input  wire logic                   prog_data_pin_in,
    output var  logic                   prog_data_pin_out,
    output var  logic                   prog_data_pin_oe
);

    // ========================================================================
    // State
    // ========================================================================
    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_PROG, ST_ERASE} state_t;

    state_t               state, next_state;
    pflash_pkg::tbl_req_t cur, next_cur, sel, ser_req, next_ser_req;
    logic [7:0]           cur_page, next_cur_page, next_page, ser_page, next_ser_page;
    logic                 src_ser, next_src_ser, next_ready;
    logic [5:0]           prog_idx, next_idx;
    pflash_pkg::fl_cmd_t  next_fl;
    pflash_pkg::tbl_resp_t next_resp;
    logic                 take_ser, sout_load, lat_we;
    logic [5:0]           lat_idx;
    logic [23:0]          lat_old, lat_wd;
    logic [15:0]          rd_fmt;
    logic [23:0]          latch [pflash_pkg::ROW_INSTR];

    // Serial side state.
    logic                 pc_s1, pc_s2, pc_s3, pd_s1, pd_s2, rise;
    logic [47:0]          ser_sr, next_sr, frame;
    logic [5:0]           ser_cnt, next_cnt;
    logic                 ser_pend, next_pend;
    logic [15:0]          sout, next_sout;
    logic [4:0]           sout_cnt, next_scnt;

    // ========================================================================
    // Request selection and read formatting
    // ========================================================================
    // Core requests win over a pending serial frame; the serial side only
    // waits, so a busy core can starve it but never corrupts it.
    always_comb begin
        sel = core_req.valid ? core_req : ser_req;
    end

    // Read data steering by half and size.
    always_comb begin
        rd_fmt = 16'h0000;
        if (cur.high) begin
            if (!(cur.byte_mode && cur.effective_addr[0])) begin
                rd_fmt[7:0] = flash_rdata[23:16];
            end
        end else if (cur.byte_mode) begin
            rd_fmt[7:0] = cur.effective_addr[0] ? flash_rdata[15:8] : flash_rdata[7:0];
        end else begin
            rd_fmt = flash_rdata[15:0];
        end
    end

    // Latch merge for a table write; untouched lanes keep their value.
    always_comb begin
        lat_idx = sel.effective_addr[6:1];
        lat_old = latch[lat_idx];
        lat_wd  = lat_old;
        if (sel.high) begin
            if (!(sel.byte_mode && sel.effective_addr[0])) begin
                lat_wd[23:16] = sel.wdata[7:0];
            end
        end else if (sel.byte_mode) begin
            if (sel.effective_addr[0]) begin
                lat_wd[15:8] = sel.wdata[7:0];
            end else begin
                lat_wd[7:0] = sel.wdata[7:0];
            end
        end else begin
            lat_wd[15:0] = sel.wdata;
        end
    end

    // ========================================================================
    // Main sequencer: next values
    // ========================================================================
    always_comb begin
        next_state    = state;
        next_cur      = cur;
        next_cur_page = cur_page;
        next_src_ser  = src_ser;
        next_page     = table_page_register;
        next_idx      = prog_idx;
        next_fl       = fl_cmd;
        next_fl.valid = 1'b0;
        next_resp     = '0;
        lat_we        = 1'b0;
        take_ser      = 1'b0;
        sout_load     = 1'b0;
        unique case (state)
            ST_IDLE: begin
                if (core_req.valid || (ser_pend && !page_wr)) begin
                    take_ser      = !core_req.valid;
                    next_cur      = sel;
                    next_src_ser  = take_ser;
                    next_cur_page = take_ser ? ser_page : table_page_register;
                    next_idx      = 6'h00;
                    if (take_ser) begin
                        next_page = ser_page;
                    end
                    unique case (sel.op)
                        pflash_pkg::TBL_READ:       next_state = ST_READ;
                        pflash_pkg::TBL_WRITE: begin
                            lat_we          = 1'b1;
                            next_resp.valid = !take_ser;
                        end
                        pflash_pkg::TBL_ROW_PROG,
                        pflash_pkg::TBL_WORD_PROG:  next_state = ST_PROG;
                        pflash_pkg::TBL_PAGE_ERASE: next_state = ST_ERASE;
                    endcase
                end
                if (page_wr) begin
                    next_page = page_wdata;
                end
            end
            ST_READ: begin
                next_fl.valid = !flash_done;
                next_fl.kind  = pflash_pkg::FL_READ;
                next_fl.addr  = {cur_page, cur.effective_addr[15:1], 1'b0};
                if (flash_done) begin
                    next_state      = ST_IDLE;
                    next_resp.valid = !src_ser;
                    next_resp.rdata = rd_fmt;
                    sout_load       = src_ser;
                end
            end
            ST_PROG: begin
                next_fl.valid = !flash_done;
                next_fl.kind  = pflash_pkg::FL_WRITE;
                if (cur.op == pflash_pkg::TBL_ROW_PROG) begin
                    next_fl.addr  = {cur_page, cur.effective_addr[15:7], prog_idx, 1'b0};
                    next_fl.wdata = latch[prog_idx];
                end else begin
                    next_fl.addr  = {cur_page, cur.effective_addr[15:1], 1'b0};
                    next_fl.wdata = latch[cur.effective_addr[6:1]];
                end
                if (flash_done) begin
                    if (cur.op == pflash_pkg::TBL_ROW_PROG && prog_idx != pflash_pkg::LAST_IDX) begin
                        next_idx = prog_idx + 6'h01;
                    end else begin
                        next_state      = ST_IDLE;
                        next_resp.valid = !src_ser;
                    end
                end
            end
            ST_ERASE: begin
                next_fl.valid = !flash_done;
                next_fl.kind  = pflash_pkg::FL_ERASE;
                next_fl.addr  = {cur_page, cur.effective_addr[15:10], 10'h000};
                if (flash_done) begin
                    next_state      = ST_IDLE;
                    next_resp.valid = !src_ser;
                end
            end
        endcase
        next_ready = (next_state == ST_IDLE);
    end

    // Main sequencer registers.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state               <= ST_IDLE;
            cur                 <= '0;
            cur_page            <= pflash_pkg::PAGE_RESET;
            src_ser             <= 1'b0;
            table_page_register <= pflash_pkg::PAGE_RESET;
            prog_idx            <= 6'h00;
            fl_cmd              <= '0;
            core_resp           <= '0;
            core_ready          <= 1'b1;
        end else begin
            state               <= next_state;
            cur                 <= next_cur;
            cur_page            <= next_cur_page;
            src_ser             <= next_src_ser;
            table_page_register <= next_page;
            prog_idx            <= next_idx;
            fl_cmd              <= next_fl;
            core_resp           <= next_resp;
            core_ready          <= next_ready;
        end
    end

    // ========================================================================
    // Row latches, one entry per instruction of a row
    // ========================================================================
    for (genvar g = 0; g < pflash_pkg::ROW_INSTR; g++) begin : g_latch
        logic [23:0] next_entry;
        always_comb begin
            next_entry = latch[g];
            if (lat_we && lat_idx == 6'(g)) begin
                next_entry = lat_wd;
            end
        end
        always_ff @(posedge sys_clk or negedge nrst) begin
            if (!nrst) begin
                latch[g] <= pflash_pkg::ERASED_WORD;
            end else begin
                latch[g] <= next_entry;
            end
        end
    end

    // ========================================================================
    // Serial programming port
    // ========================================================================
    // pins synchronised twice
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pc_s1 <= 1'b0;
            pc_s2 <= 1'b0;
            pc_s3 <= 1'b0;
            pd_s1 <= 1'b0;
            pd_s2 <= 1'b0;
        end else begin
            pc_s1 <= prog_clock_pin;
            pc_s2 <= pc_s1;
            pc_s3 <= pc_s2;
            pd_s1 <= prog_data_pin_in;
            pd_s2 <= pd_s1;
        end
    end

    assign rise  = pc_s2 && !pc_s3;
    assign frame = {ser_sr[46:0], pd_s2};

    // Frame shifter and read-back shifter. Bits arriving while a frame is
    // pending or read data is still going out are dropped, not queued.
    always_comb begin
        next_sr       = ser_sr;
        next_cnt      = ser_cnt;
        next_pend     = ser_pend && !take_ser;
        next_ser_req  = ser_req;
        next_ser_page = ser_page;
        next_sout     = sout;
        next_scnt     = sout_cnt;
        if (rise) begin
            if (sout_cnt != 5'h00) begin
                next_sout = {sout[14:0], 1'b0};
                next_scnt = sout_cnt - 5'h01;
            end else if (!ser_pend) begin
                next_sr  = frame;
                next_cnt = ser_cnt + 6'h01;
                if (ser_cnt == pflash_pkg::FRAME_LAST) begin
                    next_cnt                    = 6'h00;
                    next_pend                   = (frame[42:40] <= 3'h4);
                    next_ser_req.valid          = 1'b1;
                    next_ser_req.op             = pflash_pkg::tbl_op_t'(frame[42:40]);
                    next_ser_req.high           = frame[40 + pflash_pkg::CMD_HIGH_BIT];
                    next_ser_req.byte_mode      = frame[40 + pflash_pkg::CMD_BYTE_BIT];
                    next_ser_req.effective_addr = frame[31:16];
                    next_ser_req.wdata          = frame[15:0];
                    next_ser_page               = frame[39:32];
                end
            end
        end
        if (sout_load) begin
            next_sout = rd_fmt;
            next_scnt = pflash_pkg::SOUT_BITS;
        end
    end

    // Serial registers; the data pin output is the shifter's top bit.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ser_sr            <= '0;
            ser_cnt           <= 6'h00;
            ser_pend          <= 1'b0;
            ser_req           <= '0;
            ser_page          <= pflash_pkg::PAGE_RESET;
            sout              <= 16'h0000;
            sout_cnt          <= 5'h00;
            prog_data_pin_out <= 1'b0;
            prog_data_pin_oe  <= 1'b0;
        end else begin
            ser_sr            <= next_sr;
            ser_cnt           <= next_cnt;
            ser_pend          <= next_pend;
            ser_req           <= next_ser_req;
            ser_page          <= next_ser_page;
            sout              <= next_sout;
            sout_cnt          <= next_scnt;
            prog_data_pin_out <= next_sout[15];
            prog_data_pin_oe  <= (next_scnt != 5'h00);
        end
    end

    // ========================================================================
    // Assertions
    // ========================================================================
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    AST_READ_ISSUE: assert property (
        core_ready && core_req.valid && core_req.op == pflash_pkg::TBL_READ
        |=> ##1 fl_cmd.valid && fl_cmd.kind == pflash_pkg::FL_READ)
        else $error("Accepted read did not reach the flash.");
    AST_ADDR_FORM: assert property (
        fl_cmd.valid && fl_cmd.kind == pflash_pkg::FL_READ
        |-> fl_cmd.addr[15:1] == cur.effective_addr[15:1])
        else $error("Read address low part wrong.");
    AST_PAGE_TOP: assert property (
        fl_cmd.valid |-> fl_cmd.addr[23:16] == cur_page)
        else $error("Page byte not on address bits 23:16.");
    AST_LOW_WORD: assert property (
        state == ST_READ && flash_done && !cur.high && !cur.byte_mode && !src_ser
        |=> core_resp.valid && core_resp.rdata == $past(flash_rdata[15:0]))
        else $error("Low word read data wrong.");
    AST_LOW_BYTE: assert property (
        state == ST_READ && flash_done && !cur.high && cur.byte_mode && !src_ser
        |=> core_resp.rdata[15:8] == 8'h00)
        else $error("Byte read upper half not zero.");
    AST_HIGH_LANE: assert property (
        state == ST_READ && flash_done && cur.high && !cur.byte_mode && !src_ser
        |=> core_resp.rdata == {8'h00, $past(flash_rdata[23:16])})
        else $error("High read data wrong.");
    AST_HIGH_PHANTOM: assert property (
        state == ST_READ && flash_done && cur.high && cur.byte_mode
        && cur.effective_addr[0] && !src_ser |=> core_resp.rdata == 16'h0000)
        else $error("Phantom high byte not zero.");
    AST_ROW_END: assert property (
        state == ST_PROG && flash_done && cur.op == pflash_pkg::TBL_ROW_PROG
        && prog_idx != pflash_pkg::LAST_IDX |=> state == ST_PROG ##1 fl_cmd.valid)
        else $error("Row program stopped before the last word.");
    AST_ERASE_ALIGN: assert property (
        fl_cmd.valid && fl_cmd.kind == pflash_pkg::FL_ERASE |-> fl_cmd.addr[9:0] == 10'h000)
        else $error("Erase address not page aligned.");
    AST_WRITE_SRC: assert property (
        fl_cmd.valid && fl_cmd.kind == pflash_pkg::FL_WRITE |-> $past(state) == ST_PROG)
        else $error("Flash write outside the table path.");

    COV_ROW: cover property (state == ST_PROG && flash_done && prog_idx == pflash_pkg::LAST_IDX);
    COV_ERASE: cover property (state == ST_ERASE && flash_done);
    COV_SER_READ: cover property (sout_load ##1 prog_data_pin_oe);
    COV_BYTE_WR: cover property (lat_we && sel.byte_mode);

endmodule

`default_nettype wire

/* File: tb/flash_model.sv */
// Behavioural flash macro that answers the table access block.
// Assumes one command at a time on sys_clk and a done pulse after lat cycles.
`timescale 1ns/1ps
`default_nettype none

module flash_model (
    // Clock, reset and answer delay
    input  wire logic                sys_clk,
    input  wire logic                nrst,
    input  wire logic [7:0]          lat,
    // Command port
    input  wire pflash_pkg::fl_cmd_t fl_cmd,
    output var  logic [23:0]         flash_rdata,
    output var  logic                flash_done
);
    logic [23:0] mem [int];
    int          wr_cnt;
    int          cnt;
    logic [23:0] last_addr;

    // ========================================================================
    // Command execution
    // ========================================================================
    // Read data flips whenever no answer is due, so a stale sample never matches.
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            flash_done <= 1'b0;
            flash_rdata <= 24'h5a5a5a;
            cnt <= 0;
        end else if (flash_done || !fl_cmd.valid || cnt < lat) begin
            flash_done <= 1'b0;
            flash_rdata <= ~flash_rdata;
            cnt <= (fl_cmd.valid && !flash_done) ? cnt + 1 : 0;
        end else begin
            cnt <= 0;
            flash_done <= 1'b1;
            last_addr <= fl_cmd.addr;
            if (fl_cmd.kind == pflash_pkg::FL_READ)
                flash_rdata <= mem.exists(int'(fl_cmd.addr)) ? mem[int'(fl_cmd.addr)]
                                                              : pflash_pkg::ERASED_WORD;
            if (fl_cmd.kind == pflash_pkg::FL_WRITE) begin
                mem[int'(fl_cmd.addr)] = fl_cmd.wdata;
                wr_cnt++;
            end
            if (fl_cmd.kind == pflash_pkg::FL_ERASE)
                for (int i = 0; i < 1024; i++)
                    mem.delete(int'({fl_cmd.addr[23:10], i[9:0]}));
        end
    end
endmodule

`default_nettype wire

/* File: tb/tb_program_flash_table_access.sv */
// Self-checking bench for the program flash table access block.
// Assumes the flash_model partner and the package constants of the design.
`timescale 1ns/1ps
`default_nettype none

module tb_program_flash_table_access;
    // ========================================================================
    // Signals
    // ========================================================================
    logic                  sys_clk;
    logic                  nrst;
    pflash_pkg::tbl_req_t  core_req;
    logic                  core_ready;
    pflash_pkg::tbl_resp_t core_resp;
    logic                  page_wr;
    logic [7:0]            page_wdata;
    logic [7:0]            table_page_register;
    pflash_pkg::fl_cmd_t   fl_cmd;
    logic [23:0]           flash_rdata;
    logic                  flash_done;
    logic                  prog_clock_pin;
    logic                  prog_data_pin_in;
    logic                  prog_data_pin_out;
    logic                  prog_data_pin_oe;
    int                    error_cnt;
    int                    comparisons;
    int                    wr_base;
    logic [15:0]           rd;

    // Block under test and its flash macro partner.
    program_flash_table_access DUT (
        .sys_clk             (sys_clk),
        .nrst                (nrst),
        .core_req            (core_req),
        .core_ready          (core_ready),
        .core_resp           (core_resp),
        .page_wr             (page_wr),
        .page_wdata          (page_wdata),
        .table_page_register (table_page_register),
        .fl_cmd              (fl_cmd),
        .flash_rdata         (flash_rdata),
        .flash_done          (flash_done),
        .prog_clock_pin      (prog_clock_pin),
        .prog_data_pin_in    (prog_data_pin_in),
        .prog_data_pin_out   (prog_data_pin_out),
        .prog_data_pin_oe    (prog_data_pin_oe)
    );

    flash_model u_flash (
        .sys_clk     (sys_clk),
        .nrst        (nrst),
        .lat         (8'h02),
        .fl_cmd      (fl_cmd),
        .flash_rdata (flash_rdata),
        .flash_done  (flash_done)
    );

    // ========================================================================
    // Clock and reporting
    // ========================================================================
    // Free-running 125 MHz clock.
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // Compares one value and counts the mismatch.
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Prints the verdict and ends the run.
    task automatic give_verdict();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // A wait that used up its bound counts as a mismatch and ends the run.
    task automatic time_out();
        error_cnt++;
        $display("FAIL %0t wait limit reached", $time);
        give_verdict();
    endtask

    // ========================================================================
    // Drivers
    // ========================================================================
    // One table request: held until taken, answer taken in its one cycle.
    task automatic core_op(input pflash_pkg::tbl_op_t op, input logic high,
                           input logic byte_mode, input logic [15:0] ea,
                           input logic [15:0] wdata, output logic [15:0] rdata);
        int n;
        n = 0;
        @(negedge sys_clk);
        core_req <= '{valid: 1'b1, op: op, high: high, byte_mode: byte_mode,
                      effective_addr: ea, wdata: wdata};
        while (!core_ready) begin
            if (n == 2000) time_out();
            n++;
            @(negedge sys_clk);
        end
        @(posedge sys_clk);
        @(negedge sys_clk);
        core_req <= '0;
        n = 0;
        while (!core_resp.valid) begin
            if (n == 2000) time_out();
            n++;
            @(negedge sys_clk);
        end
        rdata = core_resp.rdata;
        check(24'(core_ready), 24'h000001);
    endtask

    task automatic ser_bit(input logic b);
        @(negedge sys_clk);
        prog_data_pin_in <= b;
        repeat (4) @(negedge sys_clk);
        prog_clock_pin <= 1'b1;
        repeat (4) @(negedge sys_clk);
        prog_clock_pin <= 1'b0;
    endtask

    // ========================================================================
    // Scenarios
    // ========================================================================
    // Values held by reset.
    task automatic t_reset_values();
        check(24'(core_ready), 24'h000001);
        check(24'(table_page_register), 24'h000000);
        check(24'(prog_data_pin_oe), 24'h000000);
        check(24'(core_resp.valid), 24'h000000);
        check(24'(fl_cmd.valid), 24'h000000);
    endtask

    // Page byte load.
    task automatic t_page_load();
        @(negedge sys_clk);
        page_wr <= 1'b1;
        page_wdata <= 8'h01;
        @(negedge sys_clk);
        page_wr <= 1'b0;
        check(24'(table_page_register), 24'h000001);
    endtask

    // Latch writes, single instruction programs and reads of every lane.
    task automatic t_table_ops();
        core_op(pflash_pkg::TBL_WRITE, 1'b0, 1'b0, 16'h0010, 16'h1234, rd);
        core_op(pflash_pkg::TBL_WRITE, 1'b1, 1'b0, 16'h0010, 16'h00ab, rd);
        core_op(pflash_pkg::TBL_WRITE, 1'b1, 1'b1, 16'h0011, 16'h00cd, rd);
        core_op(pflash_pkg::TBL_WORD_PROG, 1'b0, 1'b0, 16'h0010, 16'h0000, rd);
        check(u_flash.last_addr, 24'h010010);
        core_op(pflash_pkg::TBL_READ, 1'b0, 1'b0, 16'h0010, 16'h0000, rd);
        check(24'(rd), 24'h001234);
        core_op(pflash_pkg::TBL_READ, 1'b0, 1'b1, 16'h0011, 16'h0000, rd);
        check(24'(rd), 24'h000012);
        core_op(pflash_pkg::TBL_READ, 1'b0, 1'b1, 16'h0010, 16'h0000, rd);
        check(24'(rd), 24'h000034);
        core_op(pflash_pkg::TBL_READ, 1'b1, 1'b0, 16'h0010, 16'h0000, rd);
        check(24'(rd), 24'h0000ab);
        core_op(pflash_pkg::TBL_READ, 1'b1, 1'b1, 16'h0011, 16'h0000, rd);
        check(24'(rd), 24'h000000);
        core_op(pflash_pkg::TBL_READ, 1'b1, 1'b1, 16'h0010, 16'h0000, rd);
        check(24'(rd), 24'h0000ab);
        core_op(pflash_pkg::TBL_WRITE, 1'b0, 1'b1, 16'h0021, 16'h0077, rd);
        core_op(pflash_pkg::TBL_WORD_PROG, 1'b0, 1'b0, 16'h0020, 16'h0000, rd);
        core_op(pflash_pkg::TBL_READ, 1'b0, 1'b0, 16'h0020, 16'h0000, rd);
        check(24'(rd), 24'h0077ff);
    endtask

    // Serial high read of the programmed word, read back over the data pin.
    task automatic t_serial_read();
        logic [47:0] frame;
        logic [15:0] got;
        int          n;
        frame = {8'h08, 24'h010010, 16'h0000};
        got = 16'h0000;
        n = 0;
        for (int i = 47; i >= 0; i--) begin
            ser_bit(frame[i]);
        end
        while (!prog_data_pin_oe) begin
            if (n == 200) time_out();
            n++;
            @(negedge sys_clk);
        end
        for (int i = 15; i >= 0; i--) begin
            got[i] = prog_data_pin_out;
            ser_bit(1'b0);
        end
        check(24'(got), 24'h0000ab);
        check(24'(prog_data_pin_oe), 24'h000000);
        check(24'(table_page_register), 24'h000001);
    endtask

    // Whole row program, then page erase.
    task automatic t_row_and_erase();
        wr_base = u_flash.wr_cnt;
        core_op(pflash_pkg::TBL_ROW_PROG, 1'b0, 1'b0, 16'h0080, 16'h0000, rd);
        check(24'(u_flash.wr_cnt - wr_base), 24'h000040);
        check(u_flash.last_addr, 24'h0100fe);
        core_op(pflash_pkg::TBL_READ, 1'b0, 1'b0, 16'h0090, 16'h0000, rd);
        check(24'(rd), 24'h001234);
        core_op(pflash_pkg::TBL_PAGE_ERASE, 1'b0, 1'b0, 16'h0090, 16'h0000, rd);
        check(u_flash.last_addr, 24'h010000);
        core_op(pflash_pkg::TBL_READ, 1'b0, 1'b0, 16'h0090, 16'h0000, rd);
        check(24'(rd), 24'h00ffff);
    endtask

    // Reset in mid-run, then a read right after release.
    task automatic t_mid_reset();
        @(negedge sys_clk);
        nrst = 1'b0;
        repeat (2) @(negedge sys_clk);
        check(24'(table_page_register), 24'h000000);
        nrst = 1'b1;
        check(24'(core_ready), 24'h000001);
        page_wr <= 1'b1;
        page_wdata <= 8'h01;
        @(negedge sys_clk);
        page_wr <= 1'b0;
        core_op(pflash_pkg::TBL_READ, 1'b0, 1'b0, 16'h0010, 16'h0000, rd);
        check(24'(rd), 24'h00ffff);
    endtask

    // ========================================================================
    // Sequence
    // ========================================================================
    initial begin
        nrst = 1'b0;
        core_req = '0;
        page_wr = 1'b0;
        page_wdata = 8'h00;
        prog_clock_pin = 1'b0;
        prog_data_pin_in = 1'b0;
        error_cnt = 0;
        comparisons = 0;
        repeat (4) @(negedge sys_clk);
        nrst = 1'b1;
        t_reset_values();
        t_page_load();
        t_table_ops();
        t_serial_read();
        t_row_and_erase();
        t_mid_reset();
        give_verdict();
    end
endmodule

`default_nettype wire
